//--- include/swr_defs.svh
`ifndef SWR_DEFS_SVH
`define SWR_DEFS_SVH

// ==========================================================
// Clock and timing figures
`define SWR_CLK_HZ       100000000
`define SWR_RESET_MS     700
`define SWR_TIMEOUT_MS   700
`define SWR_STROBE_NS    500
`define SWR_OVR_DEB_NS   10000

// ==========================================================
// Register byte offsets
`define SWR_CTRL_OFS     4'h0
`define SWR_STAT_OFS     4'h4
`define SWR_WDT_OFS      4'h8
`define SWR_TIMER_OFS    4'hc

// ==========================================================
// Field positions
`define SWR_CTRL_WDT_EN  0
`define SWR_CTRL_FORCE   1
`define SWR_ST_DRIVE     0
`define SWR_ST_SUPPLY    1
`define SWR_ST_RUN       2
`define SWR_ST_WDT_EVT   8
`define SWR_ST_OVR_EVT   9
`define SWR_ST_PWR_EVT   10
`define SWR_ST_SW_EVT    11

// ==========================================================
// Reset values
`define SWR_WDT_EN_RST   1'b1
`define SWR_PINS_RST     3'h1

`endif

//--- include/swr_pkg.sv
`default_nettype none

package swr_pkg;

   typedef enum logic [2:0]
   {
      SWR_POWER = 3'h1,
      SWR_HOLD  = 3'h2,
      SWR_RUN   = 3'h4
   } swr_fsm_type;

   typedef struct packed
   {
      logic supply_ok;
      logic strobe_lvl;
      logic pin_high;
   } swr_pins_type;

   typedef struct packed
   {
      swr_pins_type s1;
      swr_pins_type s2;
   } swr_sync_type;

   typedef struct packed
   {
      logic wdt;
      logic ovr;
      logic pwr;
      logic sw;
   } swr_evt_type;

   typedef struct packed
   {
      swr_fsm_type fsm;
      logic        drive;
      logic [31:0] timer;
      logic [31:0] wdt;
      logic [15:0] strb_cnt;
      logic [15:0] ovr_cnt;
      logic        wdt_en;
      swr_evt_type evt;
      logic        ack;
      logic [31:0] rdata;
   } swr_state_type;

endpackage : swr_pkg

`default_nettype wire

//--- rtl/swr_sync.sv
`include "swr_defs.svh"
`default_nettype none

module swr_sync
   import swr_pkg::*;
(
   input  wire logic         clk_in,
   input  wire logic         srst_in,
   input  wire logic         ce_in,
   input  wire swr_pins_type pins_in,
   output var swr_pins_type  pins_out
);

   swr_sync_type st_reg;
   swr_sync_type st_next;

   // First stage feeds only the second stage
   always_comb
   begin
      st_next.s1 = pins_in;
      st_next.s2 = st_reg.s1;
   end

   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         st_reg <= {`SWR_PINS_RST, `SWR_PINS_RST};
      end
      else if (ce_in)
      begin
         st_reg <= st_next;
      end
   end

   assign pins_out = st_reg.s2;

endmodule : swr_sync

`default_nettype wire

//--- rtl/swr_supervisor.sv
// Chosen here: register access over Avalon-MM and the register offsets.
`include "swr_defs.svh"
`default_nettype none

// Notes on behaviour
// R1: Low supply drives the pin low at once.
// R2: Pin is low from power application (reset) onward.
// R3: Pin stays low for the reset time after supply recovers.
// R4: Pin is open drain: only pulled low, otherwise released.
// R5: Strobe level on the released pin clears the watchdog.
// R6: Processor holds each strobe for at least 500 ns.
// R7: Missing strobe for a timeout period starts a reset.
// R8: Timeout is nominally 700 ms from last strobe or release.
// R9: Watchdog reset pulse lasts the 500..900 ms reset time.
// R10: Repeated pulses follow each timeout until a strobe comes.
// R11: External low on the pin is taken as a reset request.
// R12: Processor strobes within every timeout period.
// R13: Pin is held low during supply ramp down too.
// R14: External low is debounced and stretched to a full pulse.
// R15: Durations come from clock counters; watchdog restarts.
// R16: In run, only the strobe comparator or a low wdt_en clears the watchdog.
module swr_supervisor
   import swr_pkg::*;
#(
   parameter int unsigned RESET_CYCLES   =
      `SWR_RESET_MS * (`SWR_CLK_HZ / 1000),
   parameter int unsigned TIMEOUT_CYCLES =
      `SWR_TIMEOUT_MS * (`SWR_CLK_HZ / 1000)
)
(
   input  wire logic        clk_in,
   input  wire logic        srst_in,
   input  wire logic        ce_in,
   input  wire logic        supply_ok_in,
   input  wire logic        strobe_low_level_in,
   input  wire logic        reset_strobe_pin_in,
   output logic             reset_strobe_pin_out,
   output logic             reset_strobe_pin_oe_out,
   input  wire logic [3:0]  avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [31:0] avs_writedata_in,
   input  wire logic [3:0]  avs_byteenable_in,
   output logic [31:0]      avs_readdata_out,
   output logic             avs_waitrequest_out
);

   // =======================================================
   // Derived counts
   localparam int unsigned STROBE_CYC =
      `SWR_STROBE_NS * (`SWR_CLK_HZ / 1000000) / 1000;
   localparam int unsigned OVR_CYC =
      `SWR_OVR_DEB_NS * (`SWR_CLK_HZ / 1000000) / 1000;
   // Half the least strobe, so sync jitter cannot miss one
   localparam logic [15:0] STROBE_FILT = 16'(STROBE_CYC / 2);
   localparam logic [15:0] OVR_FILT    = 16'(OVR_CYC);
   localparam logic [31:0] RESET_LAST  = 32'(RESET_CYCLES - 1);
   localparam logic [31:0] WDT_LAST    = 32'(TIMEOUT_CYCLES - 1);

   if (RESET_CYCLES < 2 || TIMEOUT_CYCLES < 2 ||
       STROBE_CYC / 2 < 1 || OVR_CYC < 1 || OVR_CYC > 65535)
   begin : g_bad_param
      $error("swr_supervisor: unusable timing parameters");
   end

   // =======================================================
   // Filter step shared by strobe and override detectors
   function automatic logic [15:0] filt_step
   (
      input logic [15:0] cnt,
      input logic        lvl,
      input logic [15:0] lim
   );
      logic [15:0] res;
      res = 16'h0;
      if (lvl)
      begin
         res = (cnt == lim) ? cnt : cnt + 16'h1;
      end
      return res;
   endfunction : filt_step

   // =======================================================
   // Pin sensing
   swr_pins_type pins_raw;
   swr_pins_type pins_s;

   assign pins_raw.supply_ok  = supply_ok_in;
   assign pins_raw.strobe_lvl = strobe_low_level_in;
   assign pins_raw.pin_high   = reset_strobe_pin_in;

   swr_sync u_sync
   (
      .clk_in   (clk_in),
      .srst_in  (srst_in),
      .ce_in    (ce_in),
      .pins_in  (pins_raw),
      .pins_out (pins_s)
   );

   swr_state_type st_reg;
   swr_state_type st_next;

   logic strobe_lvl;
   logic ovr_lvl;
   logic strobe_hit;
   logic ovr_hit;
   logic req;
   logic acc;
   logic wr_go;
   logic force_req;

   // Own drive pulls the pin low, so sense only when released
   assign strobe_lvl = ~st_reg.drive & pins_s.strobe_lvl
                       & pins_s.pin_high;              // R5 R16
   assign ovr_lvl    = ~st_reg.drive & ~pins_s.pin_high; // R11
   assign strobe_hit = strobe_lvl &
                       (st_reg.strb_cnt == STROBE_FILT - 16'h1); // R6
   assign ovr_hit    = ovr_lvl &
                       (st_reg.ovr_cnt == OVR_FILT - 16'h1);     // R14

   // =======================================================
   // Avalon slave: one wait state per access
   assign req   = avs_read_in | avs_write_in;
   assign acc   = req & ~st_reg.ack;
   assign wr_go = avs_write_in & st_reg.ack;
   assign force_req = wr_go & avs_byteenable_in[0] &
                      (avs_address_in == `SWR_CTRL_OFS) &
                      avs_writedata_in[`SWR_CTRL_FORCE];

   // Frozen clock enable keeps the master waiting
   assign avs_waitrequest_out = req & ~(st_reg.ack & ce_in);
   assign avs_readdata_out    = st_reg.rdata;

   // =======================================================
   // Next state
   always_comb
   begin
      st_next     = st_reg;
      st_next.ack = acc;

      if (acc && avs_read_in)
      begin
         st_next.rdata = 32'h0;
         unique case (avs_address_in)
            `SWR_CTRL_OFS:
            begin
               st_next.rdata[`SWR_CTRL_WDT_EN] = st_reg.wdt_en;
            end
            `SWR_STAT_OFS:
            begin
               st_next.rdata[`SWR_ST_DRIVE]   = st_reg.drive;
               st_next.rdata[`SWR_ST_SUPPLY]  = pins_s.supply_ok;
               st_next.rdata[`SWR_ST_RUN]     =
                  (st_reg.fsm == SWR_RUN);
               st_next.rdata[`SWR_ST_WDT_EVT] = st_reg.evt.wdt;
               st_next.rdata[`SWR_ST_OVR_EVT] = st_reg.evt.ovr;
               st_next.rdata[`SWR_ST_PWR_EVT] = st_reg.evt.pwr;
               st_next.rdata[`SWR_ST_SW_EVT]  = st_reg.evt.sw;
            end
            `SWR_WDT_OFS:
            begin
               st_next.rdata = st_reg.wdt;
            end
            `SWR_TIMER_OFS:
            begin
               st_next.rdata = st_reg.timer;
            end
            default:
            begin
               st_next.rdata = 32'h0;
            end
         endcase
      end

      if (wr_go && avs_byteenable_in[0] &&
          avs_address_in == `SWR_CTRL_OFS)
      begin
         st_next.wdt_en = avs_writedata_in[`SWR_CTRL_WDT_EN];
      end

      // Clear first, so an event in the same cycle wins
      if (wr_go && avs_byteenable_in[1] &&
          avs_address_in == `SWR_STAT_OFS)
      begin
         st_next.evt.wdt = st_reg.evt.wdt &
                           ~avs_writedata_in[`SWR_ST_WDT_EVT];
         st_next.evt.ovr = st_reg.evt.ovr &
                           ~avs_writedata_in[`SWR_ST_OVR_EVT];
         st_next.evt.pwr = st_reg.evt.pwr &
                           ~avs_writedata_in[`SWR_ST_PWR_EVT];
         st_next.evt.sw  = st_reg.evt.sw &
                           ~avs_writedata_in[`SWR_ST_SW_EVT];
      end

      st_next.strb_cnt = filt_step(st_reg.strb_cnt, strobe_lvl,
                                   STROBE_FILT);      // R16
      st_next.ovr_cnt  = filt_step(st_reg.ovr_cnt, ovr_lvl,
                                   OVR_FILT);         // R14

      unique case (st_reg.fsm)
         SWR_POWER:
         begin
            st_next.drive = 1'b1;
            st_next.timer = 32'h0;
            st_next.fsm   = SWR_HOLD;
         end
         SWR_HOLD:
         begin
            st_next.drive = 1'b1;
            st_next.timer = st_reg.timer + 32'h1;
            if (st_reg.timer == RESET_LAST)           // R3 R9
            begin
               st_next.fsm   = SWR_RUN;
               st_next.drive = 1'b0;
               st_next.timer = 32'h0;
               st_next.wdt   = 32'h0;                 // R15
            end
         end
         SWR_RUN:
         begin
            if (ovr_hit || force_req)                 // R11 R14
            begin
               st_next.fsm     = SWR_HOLD;
               st_next.drive   = 1'b1;
               st_next.timer   = 32'h0;
               st_next.evt.ovr = st_next.evt.ovr | ovr_hit;
               st_next.evt.sw  = st_next.evt.sw | force_req;
            end
            else if (strobe_hit || !st_reg.wdt_en)
            begin
               st_next.wdt = 32'h0;                   // R5
            end
            else if (st_reg.wdt == WDT_LAST)          // R7 R8 R10
            begin
               st_next.fsm     = SWR_HOLD;
               st_next.drive   = 1'b1;
               st_next.timer   = 32'h0;
               st_next.evt.wdt = 1'b1;
            end
            else
            begin
               st_next.wdt = st_reg.wdt + 32'h1;      // R15
            end
         end
         default:
         begin
            st_next.fsm   = SWR_POWER;
            st_next.drive = 1'b1;
         end
      endcase

      // Supply loss overrides everything, ramp up and down
      if (!pins_s.supply_ok)                          // R1 R13
      begin
         st_next.fsm     = SWR_POWER;
         st_next.drive   = 1'b1;
         st_next.timer   = 32'h0;
         st_next.wdt     = 32'h0;
         st_next.evt.pwr = 1'b1;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         st_reg        <= '0;
         st_reg.fsm    <= SWR_POWER;
         st_reg.drive  <= 1'b1;                       // R2
         st_reg.wdt_en <= `SWR_WDT_EN_RST;
      end
      else if (ce_in)
      begin
         st_reg <= st_next;
      end
   end

   // =======================================================
   // Open-drain pin
   assign reset_strobe_pin_out    = 1'b0;             // R4
   assign reset_strobe_pin_oe_out = st_reg.drive | srst_in |
                                    ~pins_s.supply_ok; // R1 R2

   // =======================================================
   // Checks
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (srst_in);

   property p_supply_drive;
      !pins_s.supply_ok |-> reset_strobe_pin_oe_out &&
                            st_next.fsm == SWR_POWER;
   endproperty
   a_supply_drive: assert property (p_supply_drive) // R1
      else $error("supply low but pin not pulled");

   property p_reset_release;
      $past(srst_in) |-> reset_strobe_pin_oe_out &&
                         st_reg.fsm == SWR_POWER;
   endproperty
   a_reset_release: assert property (p_reset_release) // R2
      else $error("pin not low after reset");

   property p_hold_length;
      ($past(st_reg.fsm) == SWR_HOLD && st_reg.fsm == SWR_RUN)
         |-> $past(st_reg.timer) == RESET_LAST && !st_reg.drive;
   endproperty
   a_hold_length: assert property (p_hold_length) // R3
      else $error("reset pulse ended at wrong count");

   property p_open_drain;
      reset_strobe_pin_out == 1'b0;
   endproperty
   a_open_drain: assert property (p_open_drain) // R4
      else $error("pin driven high");

   property p_strobe_clear;
      (ce_in && st_reg.fsm == SWR_RUN && strobe_hit && !ovr_hit
       && !force_req && pins_s.supply_ok) |=> st_reg.wdt == 32'h0;
   endproperty
   a_strobe_clear: assert property (p_strobe_clear) // R5
      else $error("strobe did not clear watchdog");

   property p_timeout;
      (ce_in && st_reg.fsm == SWR_RUN && st_reg.wdt == WDT_LAST && !ovr_hit &&
       st_reg.wdt_en && !strobe_hit && !force_req && pins_s.supply_ok)
         |=> st_reg.fsm == SWR_HOLD && st_reg.evt.wdt &&
             reset_strobe_pin_oe_out;
   endproperty
   a_timeout: assert property (p_timeout) // R7
      else $error("no reset at watchdog timeout");

   property p_wdt_bound;
      st_reg.wdt <= WDT_LAST;
   endproperty
   a_wdt_bound: assert property (p_wdt_bound) // R8
      else $error("watchdog count passed timeout");

   property p_restart;
      ($past(st_reg.fsm) == SWR_HOLD && st_reg.fsm == SWR_RUN)
         |-> st_reg.wdt == 32'h0 ##1 st_reg.wdt <= 32'h1;
   endproperty
   a_restart: assert property (p_restart) // R15
      else $error("watchdog not restarted after pulse");

   property p_override;
      (ce_in && st_reg.fsm == SWR_RUN && ovr_hit &&
       pins_s.supply_ok) |=> st_reg.fsm == SWR_HOLD &&
                             st_reg.timer == 32'h0 && st_reg.drive;
   endproperty
   a_override: assert property (p_override) // R11
      else $error("override not taken as reset");

   property p_ovr_filter;
      (ce_in && !ovr_lvl) |=> st_reg.ovr_cnt == 16'h0;
   endproperty
   a_ovr_filter: assert property (p_ovr_filter) // R14
      else $error("override debounce not restarted");

   property p_power_hold;
      st_reg.fsm == SWR_POWER |-> reset_strobe_pin_oe_out;
   endproperty
   a_power_hold: assert property (p_power_hold) // R13
      else $error("pin released in power state");

   property p_strobe_only;
      (ce_in && !pins_s.strobe_lvl) |=> st_reg.strb_cnt == 16'h0;
   endproperty
   a_strobe_only: assert property (p_strobe_only) // R16
      else $error("strobe filter ran without strobe level");

   c_wdt_reset: cover property (st_reg.fsm == SWR_RUN ##1
                                st_reg.evt.wdt && st_reg.drive);
   c_strobe:    cover property (strobe_hit && st_reg.wdt > 32'h0);
   c_override:  cover property (ovr_hit && st_reg.fsm == SWR_RUN);
   c_power:     cover property ($fell(pins_s.supply_ok));

endmodule : swr_supervisor

`default_nettype wire

//--- verification/swr_cpu_model.sv
`default_nettype none

// ==========================================================
// Processor side of the reset/strobe pin
module swr_cpu_model
#(
   parameter int unsigned STROBE_CYCLES = 50
)
(
   input  wire logic        clk_in,
   input  wire logic        srst_in,
   input  wire logic        pin_oe_in,
   input  wire logic        button_in,
   input  wire logic        auto_in,
   input  wire logic [15:0] gap_in,
   output logic             strobe_lvl_out,
   output logic             pin_high_out
);
   timeunit 1ns;
   timeprecision 1ns;

   typedef struct packed
   {
      logic [15:0] gap;
      logic [7:0]  wid;
   } swr_cpu_state_type;

   swr_cpu_state_type state_reg;
   swr_cpu_state_type state_next;
   logic              pin_low;

   // Wired-OR: device drain or button pulls the pin fully low
   assign pin_low        = pin_oe_in | button_in;
   // Released pin rises through the divider pull-up
   assign pin_high_out   = ~pin_low;
   // Full low also sits below the strobe level
   assign strobe_lvl_out = pin_low | (state_reg.wid != 8'h00);

   always_comb
   begin
      state_next = state_reg;
      // Held in reset: no software runs, so no strobes
      if (!auto_in || pin_low)
      begin
         state_next = '0;
      end
      else if (state_reg.wid != 8'h00)
      begin
         state_next.wid = state_reg.wid - 8'h01;
      end
      else if (state_reg.gap >= gap_in)
      begin
         state_next.gap = 16'h0000;
         state_next.wid = 8'(STROBE_CYCLES);
      end
      else
      begin
         state_next.gap = state_reg.gap + 16'h0001;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (srst_in)
         state_reg <= '0;
      else
         state_reg <= state_next;
   end

endmodule : swr_cpu_model

`default_nettype wire

//--- verification/swr_supervisor_test.sv
`default_nettype none

module swr_supervisor_test;
   timeunit 1ns;
   timeprecision 1ns;

   localparam int unsigned RST_C = 200;
   localparam int unsigned TO_C  = 300;

   logic        clk_in    = 1'b0;
   logic        srst_in   = 1'b1;
   logic        ce        = 1'b1;
   logic        supply_ok = 1'b0;
   logic        button    = 1'b0;
   logic        auto_on   = 1'b0;
   logic [15:0] gap       = 16'h0064;
   logic [3:0]  address   = 4'h0;
   logic        read      = 1'b0;
   logic        write     = 1'b0;
   logic [31:0] wdata     = 32'h0000_0000;
   logic [3:0]  ben       = 4'hf;
   logic        strobe_lvl;
   logic        pin_high;
   logic        pin_oe;
   logic        pin_data;
   logic        waitreq;
   logic [31:0] rdata;
   int          num_errors  = 0;
   int          checks_done = 0;
   int          cyc         = 0;

   always #5 clk_in = ~clk_in;

   always @(posedge clk_in)
      cyc <= cyc + 1;

   swr_supervisor #(.RESET_CYCLES(RST_C), .TIMEOUT_CYCLES(TO_C)) dut
   (
      .clk_in                  (clk_in),
      .srst_in                 (srst_in),
      .ce_in                   (ce),
      .supply_ok_in            (supply_ok),
      .strobe_low_level_in     (strobe_lvl),
      .reset_strobe_pin_in     (pin_high),
      .reset_strobe_pin_out    (pin_data),
      .reset_strobe_pin_oe_out (pin_oe),
      .avs_address_in          (address),
      .avs_read_in             (read),
      .avs_write_in            (write),
      .avs_writedata_in        (wdata),
      .avs_byteenable_in       (ben),
      .avs_readdata_out        (rdata),
      .avs_waitrequest_out     (waitreq)
   );

   swr_cpu_model cpu
   (
      .clk_in         (clk_in),
      .srst_in        (srst_in),
      .pin_oe_in      (pin_oe),
      .button_in      (button),
      .auto_in        (auto_on),
      .gap_in         (gap),
      .strobe_lvl_out (strobe_lvl),
      .pin_high_out   (pin_high)
   );

   // ==========================================================
   // Checking helpers
   task end_sim;
      if (num_errors == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : end_sim

   task check(input logic [31:0] seen, input logic [31:0] exp,
              input string msg);
      checks_done++;
      if (seen !== exp)
      begin
         $display("CHECK FAILED at %0t: %s seen %h exp %h",
                  $time, msg, seen, exp);
         num_errors++;
      end
   endtask : check

   function automatic logic [31:0] in_win(input int n, input int lo,
                                          input int hi);
      return (n >= lo && n <= hi) ? 32'h1 : 32'h0;
   endfunction : in_win

   // Bounded so a stuck pin cannot hang the run
   task wait_oe(input logic lvl);
      int n;
      n = 0;
      while (pin_oe !== lvl && n < 5000)
      begin
         @(posedge clk_in);
         n++;
      end
      if (n >= 5000)
         check(32'h0, 32'h1, "pin drive wait");
   endtask : wait_oe

   task hold_oe(input logic lvl, input int cycles);
      int bad;
      bad = 0;
      repeat (cycles)
      begin
         @(posedge clk_in);
         if (pin_oe !== lvl)
            bad++;
      end
      check(32'(bad), 32'h0, "pin drive moved");
   endtask : hold_oe

   // ==========================================================
   // Avalon master: hold request until waitrequest sampled low
   task bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
            input logic [3:0] be, output logic [31:0] d);
      int n;
      address <= a;
      wdata   <= wd;
      ben     <= be;
      read    <= ~wr;
      write   <= wr;
      n = 0;
      do
      begin
         @(posedge clk_in);
         n++;
      end
      while (waitreq !== 1'b0 && n < 100);
      d = rdata;
      read  <= 1'b0;
      write <= 1'b0;
      @(posedge clk_in);
      if (n >= 100)
         check(32'h0, 32'h1, "bus wait");
   endtask : bus

   // ==========================================================
   // Main sequence
   initial
   begin
      int          t0;
      int          f;
      logic [31:0] d;
      void'($urandom(32'h0cd37224));
      repeat (3) @(posedge clk_in);
      check({31'h0, pin_oe}, 32'h1, "drive in reset");
      repeat (2) @(posedge clk_in);
      srst_in <= 1'b0;
      repeat (10) @(posedge clk_in);
      check({31'h0, pin_oe}, 32'h1, "drive supply low");
      check({31'h0, pin_data}, 32'h0, "drain data");
      supply_ok <= 1'b1;
      t0 = cyc;
      wait_oe(1'b0);
      check(in_win(cyc - t0, RST_C, RST_C + 5), 1, "power hold");
      bus(1'b0, 4'h0, 32'h0, 4'hf, d);
      check(d, 32'h1, "ctrl reset value");
      bus(1'b0, 4'h4, 32'h0, 4'hf, d);
      check(d & 32'h7, 32'h6, "status running");
      bus(1'b0, 4'h2, 32'h0, 4'hf, d);
      check(d, 32'h0, "unmapped read");
      // Full-low glitch must neither clear nor trip the watchdog
      t0 = cyc;
      repeat ($urandom_range(100, 20)) @(posedge clk_in);
      button <= 1'b1;
      // Glitch ends before the timeout, far below the debounce
      repeat (150) @(posedge clk_in);
      button <= 1'b0;
      wait_oe(1'b1);
      check(in_win(cyc - t0, TO_C - 16, TO_C + 3), 1, "timeout");
      t0 = cyc;
      wait_oe(1'b0);
      check(in_win(cyc - t0, RST_C - 2, RST_C + 2), 1, "wdt pulse");
      t0 = cyc;
      wait_oe(1'b1);
      check(in_win(cyc - t0, TO_C - 2, TO_C + 2), 1, "repeat");
      wait_oe(1'b0);
      bus(1'b0, 4'h4, 32'h0, 4'hf, d);
      check(d & 32'h100, 32'h100, "wdt event");
      bus(1'b1, 4'h4, 32'h100, 4'h2, d);
      bus(1'b0, 4'h4, 32'h0, 4'hf, d);
      check(d & 32'h100, 32'h0, "wdt event clear");
      gap     <= 16'($urandom_range(200, 60));
      auto_on <= 1'b1;
      hold_oe(1'b0, 3 * TO_C);
      // Watchdog off: strobes stop while the pin is held low
      bus(1'b1, 4'h0, 32'h0, 4'hf, d);
      button <= 1'b1;
      t0 = cyc;
      wait_oe(1'b1);
      check(in_win(cyc - t0, 998, 1008), 1, "override");
      t0 = cyc;
      repeat (20) @(posedge clk_in);
      button <= 1'b0;
      wait_oe(1'b0);
      check(in_win(cyc - t0, RST_C - 2, RST_C + 2), 1, "stretch");
      supply_ok <= 1'b0;
      t0 = cyc;
      wait_oe(1'b1);
      check(in_win(cyc - t0, 1, 4), 1, "supply drop");
      hold_oe(1'b1, 100);
      supply_ok <= 1'b1;
      t0 = cyc;
      wait_oe(1'b0);
      check(in_win(cyc - t0, RST_C, RST_C + 5), 1, "ramp up");
      t0 = cyc;
      bus(1'b1, 4'h0, 32'h3, 4'hf, d);
      wait_oe(1'b1);
      bus(1'b0, 4'h4, 32'h0, 4'hf, d);
      check(d & 32'hf01, 32'he01, "force event");
      bus(1'b0, 4'hc, 32'h0, 4'hf, d);
      check(in_win(int'(d), 3, 5), 1, "pulse timer");
      // Frozen clock enable must stretch the pulse exactly
      f = $urandom_range(40, 10);
      ce <= 1'b0;
      repeat (f) @(posedge clk_in);
      ce <= 1'b1;
      wait_oe(1'b0);
      check(in_win(cyc - t0, RST_C + f + 1, RST_C + f + 5), 1,
            "freeze");
      auto_on <= 1'b0;
      bus(1'b1, 4'h0, 32'h0, 4'hf, d);
      bus(1'b1, 4'h8, $urandom, 4'hf, d);
      hold_oe(1'b0, 2 * TO_C);
      bus(1'b0, 4'h8, 32'h0, 4'hf, d);
      check(d, 32'h0, "disabled count");
      end_sim;
   end

   // Normal run is about 5000 cycles
   initial
   begin
      repeat (20000) @(posedge clk_in);
      num_errors++;
      end_sim;
   end

endmodule : swr_supervisor_test

`default_nettype wire
